// ==== dv/tsf_ctrl_test.sv ====
// Self-checking bench for the synchronizer function control
`timescale 1ns/1ps
module tsf_ctrl_test;
	logic        clk = 0, rst_n = 0, fcStrobe = 0, accInput = 0, outInstr = 0;
	logic        outValid = 0, outDone = 0, blockInput = 0, fcRejected, outAccept, statusValid, wrStrobe;
	logic        parityOdd, wideMode, parityErr, rbStrobe;
	logic [11:0] fcCode = '0, outData = '0, statusWord;
	logic [7:0]  hGap, hFileMark, hLoadPoint, motFwd, motRev, ignoreGap, rewindCmd, unloadCmd;
	logic [7:0]  hUnloaded = '0;
	logic [6:0]  wrFrame, rbFrame, lrc;
	logic [2:0]  selHandler;
	logic [1:0]  densCode, densPair = '0;
	int          num_errors = 0, samples_checked = 0, cyc;
	logic [6:0]  frames[$], expq[$];
	always #5 clk = ~clk;
	always @(posedge clk) if (wrStrobe === 1'b1) frames.push_back(wrFrame);
	tsf_ctrl #(.GAP_CYC(20), .FM_GAP_CYC(30), .FRAME_CYC(5)) tsf_ctrl_inst (.clk(clk), .rst_n(rst_n),
		.fcStrobe(fcStrobe), .fcCode(fcCode), .accInput(accInput), .blockInput(blockInput), .outInstr(outInstr),
		.fcRejected(fcRejected), .outValid(outValid), .outData(outData), .outDone(outDone),
		.outAccept(outAccept), .statusWord(statusWord), .statusValid(statusValid), .hGap(hGap),
		.hFileMark(hFileMark), .hLoadPoint(hLoadPoint), .hUnloaded(hUnloaded), .rbStrobe(rbStrobe),
		.rbFrame(rbFrame), .densPair(densPair), .motFwd(motFwd), .motRev(motRev), .ignoreGap(ignoreGap),
		.rewindCmd(rewindCmd), .unloadCmd(unloadCmd), .wrFrame(wrFrame), .wrStrobe(wrStrobe),
		.selHandler(selHandler), .densCode(densCode), .parityOdd(parityOdd), .wideMode(wideMode),
		.parityErr(parityErr));
	tsf_handler_model #(.N(8)) tsf_handler_model_inst (.clk(clk), .rst_n(rst_n), .motFwd(motFwd),
		.motRev(motRev), .ignoreGap(ignoreGap), .rewindCmd(rewindCmd), .wrStrobe(wrStrobe),
		.wrFrame(wrFrame), .hGap(hGap), .hFileMark(hFileMark), .hLoadPoint(hLoadPoint),
		.rbStrobe(rbStrobe), .rbFrame(rbFrame));
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic fc(logic [11:0] c, logic a, logic o, logic rej);
		@(posedge clk);
		fcStrobe <= 1'b1;
		fcCode <= c;
		accInput <= a;
		outInstr <= o;
		@(posedge clk);
		fcStrobe <= 1'b0;
		#1 chk(fcRejected, rej);
	endtask
	task automatic waitFor(int tick);
		// Bounded wait for the handler's motion to end
		for (cyc = 0; motFwd[tick] | motRev[tick] | ignoreGap[tick]; cyc++)
		begin
			if (cyc > 3000)
			begin
				num_errors++;
				tally_and_finish();
			end
			@(posedge clk) #1;
		end
	endtask
	task automatic word(logic [11:0] d);
		@(posedge clk);
		outData <= d;
		outValid <= 1'b1;
		for (cyc = 0; outAccept !== 1'b1; cyc++)
		begin
			if (cyc > 200)
			begin
				num_errors++;
				tally_and_finish();
			end
			@(posedge clk) #1;
		end
		@(posedge clk) outValid <= 1'b0;
	endtask
	function automatic logic [6:0] pf(logic [5:0] c, logic odd);
		return {^c ^ odd, c};
	endfunction
	task automatic wrTest(logic [2:0] y, logic [2:0] h, logic [11:0] d0, logic [11:0] d1, logic odd);
		frames.delete();
		expq.delete();
		fc({y, 3'h1, tsf_pkg::FN_WRITE, h}, 1'b0, 1'b1, 1'b0);
		chk(motFwd[h], 1'b1);
		chk(selHandler, h);
		word(d0);
		chk(cyc >= 20, 1'b1);
		word(d1);
		outDone <= 1'b1;
		waitFor(h);
		@(posedge clk) outDone <= 1'b0;
		lrc = 7'h00;
		for (int k = 0; k < 2; k++)
		begin
			if (y == 3'h2)
				expq.push_back(pf(k ? d1[11:6] : d0[11:6], odd));
			expq.push_back(pf(k ? d1[5:0] : d0[5:0], odd));
		end
		foreach (expq[k]) lrc ^= expq[k];
		expq.push_back(lrc);
		chk(frames.size(), expq.size());
		foreach (expq[k]) chk(frames[k], expq[k]);
		chk(parityErr, 1'b0);
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk(parityOdd, 1'b1);
		fc(12'o2172, 1'b0, 1'b0, 1'b0);
		chk({parityOdd, wideMode}, 2'b00);
		wrTest(3'h2, 3'h3, 12'o1234, 12'o7701, 1'b0);
		fc(12'o1171, 1'b0, 1'b0, 1'b0);
		chk({parityOdd, wideMode}, 2'b11);
		wrTest(3'h1, 3'h5, 12'o5522, 12'o0077, 1'b1);
		// File mark record: one even-parity frame, then its check frame
		frames.delete();
		fc(12'o1113, 1'b0, 1'b0, 1'b0);
		waitFor(3);
		chk(frames.size(), 2);
		chk({frames[0], frames[1]}, 14'h078F);
		chk(parityErr, 1'b0);
		fc(12'o1272, 1'b0, 1'b0, 1'b0);
		chk(parityOdd, 1'b1);
		fc(12'o1124, 1'b1, 1'b0, 1'b0);
		chk({motRev[4], ignoreGap[4]}, 2'b10);
		waitFor(4);
		fc(12'o1121, 1'b0, 1'b0, 1'b0);
		chk({motRev[1], ignoreGap[1]}, 2'b11);
		fc(12'o1146, 1'b0, 1'b0, 1'b0);
		chk({statusValid, statusWord}, 13'h1080);
		fc(12'o1131, 1'b0, 1'b0, 1'b1);
		waitFor(1);
		// Old file mark sense must drain, or it ends the next search at once
		repeat (4) @(posedge clk);
		fc(12'o1131, 1'b0, 1'b0, 1'b0);
		chk({motFwd[1], ignoreGap[1]}, 2'b11);
		waitFor(1);
		fc(12'o1162, 1'b0, 1'b0, 1'b0);
		chk(rewindCmd[2], 1'b1);
		fc(12'o1132, 1'b0, 1'b0, 1'b1);
		// Twelve-bit mode before high density keeps the host legal
		fc(12'o2135, 1'b0, 1'b0, 1'b0);
		waitFor(5);
		repeat (40) @(posedge clk);
		fc(12'o1122, 1'b0, 1'b0, 1'b1);
		fc(12'o1105, 1'b0, 1'b0, 1'b0);
		repeat (2) @(posedge clk);
		#1 chk(densCode, tsf_pkg::DENS_200);
		fc(12'o2105, 1'b0, 1'b0, 1'b0);
		repeat (2) @(posedge clk);
		#1 chk(densCode, tsf_pkg::DENS_556);
		@(posedge clk) densPair <= 2'h1;
		repeat (4) @(posedge clk);
		#1 chk(densCode, tsf_pkg::DENS_800);
		fc(12'o1132, 1'b0, 1'b0, 1'b0);
		waitFor(2);
		@(posedge clk) blockInput <= 1'b1;
		fc(12'o1133, 1'b0, 1'b0, 1'b0);
		chk({motFwd[3], ignoreGap[3]}, 2'b00);
		@(posedge clk) blockInput <= 1'b0;
		fc(12'o1154, 1'b0, 1'b0, 1'b0);
		chk(unloadCmd[4], 1'b1);
		@(posedge clk) hUnloaded <= 8'h10;
		repeat (4) @(posedge clk);
		fc(12'o1134, 1'b0, 1'b0, 1'b1);
		fc(12'o1144, 1'b0, 1'b0, 1'b0);
		chk({statusValid, statusWord}, 13'h1002);
		tally_and_finish();
	end
endmodule

// ==== dv/tsf_handler_model.sv ====
// Behavioural tape handler bank facing the synchronizer
`timescale 1ns/1ps
module tsf_handler_model #(
	parameter int N = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Commands
	input  wire logic [N-1:0] motFwd,
	input  wire logic [N-1:0] motRev,
	input  wire logic [N-1:0] ignoreGap,
	input  wire logic [N-1:0] rewindCmd,
	input  wire logic         wrStrobe,
	input  wire logic [6:0]   wrFrame,
	// Sense lines
	output logic      [N-1:0] hGap,
	output logic      [N-1:0] hFileMark,
	output logic      [N-1:0] hLoadPoint,
	output logic              rbStrobe,
	output logic      [6:0]   rbFrame
);
	int quiet;
	int srch [N];
	int rew  [N];
	// Gap seen once tape has moved 40 cycles with no frame written
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			quiet <= 0;
			hGap <= '0;
			hFileMark <= '0;
			hLoadPoint <= '0;
			rbStrobe <= 1'b0;
			rbFrame <= 7'h00;
			for (int i = 0; i < N; i++)
			begin
				srch[i] <= 0;
				rew[i] <= 0;
			end
		end
		else
		begin
			rbStrobe <= wrStrobe;
			rbFrame <= wrFrame;
			quiet <= (wrStrobe || !(|(motFwd | motRev))) ? 0 : quiet + 1;
			hGap <= (quiet >= 40 && quiet < 44) ? (motFwd | motRev) : '0;
			for (int i = 0; i < N; i++)
			begin
				srch[i] <= ignoreGap[i] ? srch[i] + 1 : 0;
				hFileMark[i] <= srch[i] >= 30;
				if (rewindCmd[i])
					rew[i] <= 1;
				else if (motFwd[i])
					rew[i] <= 0;
				else if (rew[i] > 0 && rew[i] < 30)
					rew[i] <= rew[i] + 1;
				hLoadPoint[i] <= rew[i] >= 30;
			end
		end
	end
endmodule

// ==== rtl/tsf_ctrl.sv ====
// Function code interpreter and write sequencer of a tape synchronizer
//
// Overview of operation
// - Select codes with Y of 1 or 2 pick handler and word length.
// - Parity code picks odd parity on X=1, even on X=2.
// - Density code: leading digit chooses high or low, X names the handler.
// - Backward code with accumulator input backspaces to the next record gap.
// - Backward code alone searches backward, ignoring gaps, until a file mark.
// - After starting a search the synchronizer is free for other handlers.
// - A searching handler stays busy until its file mark is sensed.
// - Forward code without block input searches forward for a file mark.
// - Rewind code pulses rewind to the handler and frees the synchronizer.
// - Rewound handler at load point accepts only forward operations.
// - Unloading handler refuses all operations until manually reloaded.
// - Write code with output instruction starts forward motion for writing.
// - First output word is taken only after the record gap delay.
// - Twelve-bit mode sends two parity-tagged characters, high half first.
// - Six-bit mode sends only the low six bits with parity.
// - Each character plus parity goes out as one seven-bit frame.
// - When output words stop, a three-frame gap precedes the check character.
// - Check character holds longitudinal parity of every channel.
// - Second and third units answer to master digits 2 and 3.
// - A switch selects which density pair high and low mean.
// - Check character is recorded; read-back is checked; gap ends the write.
// - Write code alone writes a one-frame file mark record.
// - Status request returns parity, readiness, error, mark, density, busy.
`timescale 1ns/1ps
module tsf_ctrl #(
	parameter int N          = 8,
	parameter int UNIT       = 0,
	parameter int GAP_CYC    = tsf_pkg::GAP_CYC,
	parameter int FM_GAP_CYC = tsf_pkg::FM_GAP_CYC,
	parameter int FRAME_CYC  = tsf_pkg::FRAME_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Function codes from the channel
	input  wire logic        fcStrobe,
	input  wire logic [11:0] fcCode,
	input  wire logic        accInput,
	input  wire logic        blockInput,
	input  wire logic        outInstr,
	output logic             fcRejected,
	// Output words from the channel
	input  wire logic        outValid,
	input  wire logic [11:0] outData,
	input  wire logic        outDone,
	output logic             outAccept,
	// Status answer
	output logic [11:0]      statusWord,
	output logic             statusValid,
	// Handler sense pins
	input  wire logic [N-1:0] hGap,
	input  wire logic [N-1:0] hFileMark,
	input  wire logic [N-1:0] hLoadPoint,
	input  wire logic [N-1:0] hUnloaded,
	input  wire logic        rbStrobe,
	input  wire logic [6:0]  rbFrame,
	input  wire logic [1:0]  densPair,
	// Handler commands
	output logic [N-1:0]     motFwd,
	output logic [N-1:0]     motRev,
	output logic [N-1:0]     ignoreGap,
	output logic [N-1:0]     rewindCmd,
	output logic [N-1:0]     unloadCmd,
	output logic [6:0]       wrFrame,
	output logic             wrStrobe,
	output logic [2:0]       selHandler,
	output logic [1:0]       densCode,
	output logic             parityOdd,
	output logic             wideMode,
	output logic             parityErr
);
	localparam int SW = 4 * N + 10;
	localparam logic [2:0] UNIT_DIG = 3'(UNIT + 1);
	localparam int TW = tsf_pkg::TMR_W;

	tsf_pkg::tsf_state_t stateQ, stateD;
	logic [SW-1:0] syncOut;
	logic [N-1:0]  gapS, fmS, lpS, unlS, gapP, lpP;
	logic [N-1:0]  busyV, lockV, fwdOnlyV, srchEndV;
	logic          rbStbS, rbStbP;
	logic [6:0]    rbFrS;
	logic [1:0]    densS;
	logic [N-1:0]  hiDensQ;
	logic [11:0]   wordQ;
	logic [6:0]    lrcQ, rbLrcQ;
	logic          eofQ, fmRecQ;
	logic [TW-1:0] dwellQ;

	tsf_sync #(.W(SW)) u_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.din  ({densPair, rbFrame, rbStrobe, hUnloaded, hLoadPoint, hFileMark, hGap}),
		.dout (syncOut)
	);
	assign gapS   = syncOut[N-1:0];
	assign fmS    = syncOut[2*N-1:N];
	assign lpS    = syncOut[3*N-1:2*N];
	assign unlS   = syncOut[4*N-1:3*N];
	assign rbStbS = syncOut[4*N];
	assign rbFrS  = syncOut[4*N+7:4*N+1];
	assign densS  = syncOut[4*N+9:4*N+8];

	// Function code decode
	wire [2:0] fcY    = fcCode[11:9];
	wire [2:0] fcUnit = fcCode[8:6];
	wire [2:0] fcFn   = fcCode[5:3];
	wire [2:0] fcX    = fcCode[2:0];
	wire fcMine  = fcStrobe && fcUnit == UNIT_DIG
		&& (fcY == tsf_pkg::Y_NARROW || fcY == tsf_pkg::Y_WIDE);
	wire hValid  = 32'(fcX) < N;
	wire isDens  = fcFn == tsf_pkg::FN_DENS;
	wire isPar   = fcFn == tsf_pkg::FN_PARITY;
	wire isStat  = fcFn == tsf_pkg::FN_STAT;
	wire isOp    = !isDens && !isPar && !isStat;
	wire fsmIdle = stateQ == tsf_pkg::ST_IDLE;
	wire needRev = fcFn == tsf_pkg::FN_REWIND || fcFn == tsf_pkg::FN_UNLOAD
		|| (fcFn == tsf_pkg::FN_BACK);
	wire opOk    = !lockV[fcX] && !busyV[fcX]
		&& !(needRev && fwdOnlyV[fcX]);
	wire accept  = fcMine && hValid && fsmIdle && (!isOp || opOk);
	wire isRead  = fcFn == tsf_pkg::FN_FWD && blockInput;
	wire evWrite = accept && fcFn == tsf_pkg::FN_WRITE && outInstr;
	wire evWfm   = accept && fcFn == tsf_pkg::FN_WRITE && !outInstr;
	wire evBsp   = accept && fcFn == tsf_pkg::FN_BACK && accInput;
	wire evSrchR = accept && fcFn == tsf_pkg::FN_BACK && !accInput;
	wire evSrchF = accept && fcFn == tsf_pkg::FN_FWD && !blockInput;
	wire evRwd   = accept && fcFn == tsf_pkg::FN_REWIND;
	wire evUnl   = accept && fcFn == tsf_pkg::FN_UNLOAD;
	wire evSel   = accept && (isOp || isStat);
	wire [N-1:0] gapRise = gapS & ~gapP;
	wire [N-1:0] lpRise  = lpS & ~lpP;
	wire rbRise  = rbStbS && !rbStbP;
	wire evStop  = (stateQ == tsf_pkg::ST_BSP || stateQ == tsf_pkg::ST_REPLY)
		&& gapRise[selHandler];

	// Per-handler motion state; a search or rewind runs on without the sequencer
	for (genvar h = 0; h < N; h++)
	begin : g_hdl
		logic fwdQ, revQ, srchQ, rwdQ, unlQ, lockQ, fwdOnlyQ, rwdPQ, unlPQ;
		wire goH   = fcX == 3'(h);
		wire stopH = evStop && selHandler == 3'(h);
		wire sEnd  = srchQ && fmS[h];
		wire lpUp  = lpRise[h];
		assign motFwd[h]    = fwdQ;
		assign motRev[h]    = revQ;
		assign ignoreGap[h] = srchQ;
		assign rewindCmd[h] = rwdPQ;
		assign unloadCmd[h] = unlPQ;
		assign busyV[h]     = srchQ || rwdQ || unlQ;
		assign lockV[h]     = lockQ;
		assign fwdOnlyV[h]  = fwdOnlyQ;
		assign srchEndV[h]  = sEnd;
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				{fwdQ, revQ, srchQ, rwdQ, unlQ} <= 5'h00;
				{lockQ, fwdOnlyQ, rwdPQ, unlPQ} <= 4'h0;
			end
			else
			begin
				rwdPQ <= goH && evRwd;
				unlPQ <= goH && evUnl;
				if (goH && (evSrchF || evWrite || evWfm))
					fwdQ <= 1'b1;
				else if (stopH || sEnd)
					fwdQ <= 1'b0;
				if (goH && (evSrchR || evBsp))
					revQ <= 1'b1;
				else if (stopH || sEnd)
					revQ <= 1'b0;
				if (goH && (evSrchR || evSrchF))
					srchQ <= 1'b1;
				else if (sEnd)
					srchQ <= 1'b0;
				if (goH && evRwd)
					rwdQ <= 1'b1;
				else if (lpUp)
					rwdQ <= 1'b0;
				if (rwdQ && lpUp)
					fwdOnlyQ <= 1'b1;
				else if (goH && (evSrchF || evWrite || evWfm))
					fwdOnlyQ <= 1'b0;
				if (goH && evUnl)
					unlQ <= 1'b1;
				else if (unlS[h])
					unlQ <= 1'b0;
				// Reload is recognised by load point returning
				if (unlQ && unlS[h])
					lockQ <= 1'b1;
				else if (lpUp)
					lockQ <= 1'b0;
			end
		end
	end

	// Sequencer
	wire tmrDone;
	logic emit;
	logic [5:0] emitChar;
	logic emitBcd;
	always_comb
	begin
		stateD   = stateQ;
		emit     = 1'b0;
		emitChar = wordQ[5:0];
		emitBcd  = 1'b0;
		case (stateQ)
			tsf_pkg::ST_IDLE:
				if (evWrite)
					stateD = tsf_pkg::ST_WGAP;
				else if (evWfm)
					stateD = tsf_pkg::ST_FMGAP;
				else if (evBsp)
					stateD = tsf_pkg::ST_BSP;
			tsf_pkg::ST_BSP:
				if (evStop)
					stateD = tsf_pkg::ST_IDLE;
			tsf_pkg::ST_WGAP:
				if (tmrDone)
					stateD = tsf_pkg::ST_WTAKE;
			tsf_pkg::ST_WTAKE:
				if (outValid)
					stateD = tsf_pkg::ST_WHI;
				else if (outDone)
					stateD = tsf_pkg::ST_CCGAP;
			tsf_pkg::ST_WHI:
				if (tmrDone)
				begin
					emit     = 1'b1;
					emitChar = wideMode ? wordQ[11:6] : wordQ[5:0];
					stateD   = wideMode ? tsf_pkg::ST_WLO : tsf_pkg::ST_WTAKE;
				end
			tsf_pkg::ST_WLO:
				if (tmrDone)
				begin
					emit   = 1'b1;
					stateD = tsf_pkg::ST_WTAKE;
				end
			tsf_pkg::ST_CCGAP:
				if (tmrDone)
					stateD = tsf_pkg::ST_CHECK;
			tsf_pkg::ST_CHECK:
				stateD = tsf_pkg::ST_REPLY;
			tsf_pkg::ST_REPLY:
				if (evStop)
					stateD = tsf_pkg::ST_IDLE;
			tsf_pkg::ST_FMGAP:
				if (tmrDone)
					stateD = tsf_pkg::ST_FMWR;
			tsf_pkg::ST_FMWR:
				if (tmrDone)
				begin
					emit     = 1'b1;
					emitChar = tsf_pkg::FILE_MARK;
					emitBcd  = 1'b1;
					stateD   = tsf_pkg::ST_CCGAP;
				end
			default:
				stateD = tsf_pkg::ST_IDLE;
		endcase
	end

	// File mark is decimal coded, so it always carries even parity
	wire emitPar = (parityOdd && !emitBcd) ? ~^emitChar : ^emitChar;
	wire [6:0] emitFrame = {emitPar, emitChar};
	wire isCheck = stateQ == tsf_pkg::ST_CHECK;

	logic [TW-1:0] tmrVal;
	always_comb
	begin
		case (stateD)
			tsf_pkg::ST_WGAP:  tmrVal = TW'(GAP_CYC);
			tsf_pkg::ST_FMGAP: tmrVal = TW'(FM_GAP_CYC);
			tsf_pkg::ST_CCGAP: tmrVal = TW'(tsf_pkg::CC_GAP_FRAMES * FRAME_CYC);
			tsf_pkg::ST_WHI,
			tsf_pkg::ST_WLO,
			tsf_pkg::ST_FMWR:  tmrVal = TW'(FRAME_CYC);
			default:           tmrVal = '0;
		endcase
	end

	tsf_timer #(.W(TW)) u_timer (
		.clk    (clk),
		.rst_n  (rst_n),
		.load   (stateD != stateQ),
		.loadVal(tmrVal),
		.done   (tmrDone)
	);

	// Read-back checking skips the check frame, whose bit 6 is not a row parity
	wire rbChk   = rbRise && !fsmIdle && stateQ != tsf_pkg::ST_BSP
		&& stateQ != tsf_pkg::ST_REPLY && !isCheck;
	// A file mark record reads back with even parity whatever the selection
	wire rbBad   = rbFrS[6] != ((parityOdd && !fmRecQ) ? ~^rbFrS[5:0] : ^rbFrS[5:0]);
	wire lrcBad  = evStop && stateQ == tsf_pkg::ST_REPLY
		&& (rbLrcQ ^ (rbRise ? rbFrS : 7'h00)) != 7'h00;

	// Density pair from the manual switch
	wire [1:0] densLow  = (densS == tsf_pkg::PAIR_200_556 || densS == tsf_pkg::PAIR_200_800)
		? tsf_pkg::DENS_200 : tsf_pkg::DENS_556;
	wire [1:0] densHigh = (densS == tsf_pkg::PAIR_200_556) ? tsf_pkg::DENS_556 : tsf_pkg::DENS_800;

	wire [11:0] statusD = 12'(
		(!parityOdd                    ? 12'h001 << tsf_pkg::ST_EVEN : 12'h000)
		| (lockV[selHandler]           ? 12'h001 << tsf_pkg::ST_NRDY : 12'h000)
		| (parityErr                   ? 12'h001 << tsf_pkg::ST_PERR : 12'h000)
		| (eofQ                        ? 12'h001 << tsf_pkg::ST_EOF  : 12'h000)
		| (lpS[selHandler]             ? 12'h001 << tsf_pkg::ST_LDPT : 12'h000)
		| (hiDensQ[selHandler]         ? 12'h001 << tsf_pkg::ST_HIDN : 12'h000)
		| (busyV[selHandler] || !fsmIdle ? 12'h001 << tsf_pkg::ST_BUSY : 12'h000));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stateQ <= tsf_pkg::ST_IDLE;
			{gapP, lpP} <= '0;
			rbStbP <= 1'b0;
			dwellQ <= '0;
		end
		else
		begin
			stateQ <= stateD;
			gapP   <= gapS;
			lpP    <= lpS;
			rbStbP <= rbStbS;
			dwellQ <= (stateD != stateQ) ? '0 : dwellQ + TW'(1);
		end
	end

	// Selections persist until a new code replaces them
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			selHandler <= 3'h0;
			wideMode   <= tsf_pkg::RST_WIDE;
			parityOdd  <= tsf_pkg::RST_PAR_ODD;
			hiDensQ    <= '0;
			densCode   <= tsf_pkg::DENS_200;
		end
		else
		begin
			if (evSel)
			begin
				selHandler <= fcX;
				wideMode   <= fcY == tsf_pkg::Y_WIDE;
			end
			if (accept && isPar && fcX == tsf_pkg::PAR_ODD_X)
				parityOdd <= 1'b1;
			else if (accept && isPar && fcX == tsf_pkg::PAR_EVEN_X)
				parityOdd <= 1'b0;
			if (accept && isDens)
				hiDensQ[fcX] <= fcY == tsf_pkg::Y_WIDE;
			densCode <= hiDensQ[selHandler] ? densHigh : densLow;
		end
	end

	// Data path, status and error flags
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wordQ <= 12'h000;
			{outAccept, wrStrobe, statusValid, fcRejected} <= 4'h0;
			wrFrame <= 7'h00;
			lrcQ <= 7'h00;
			rbLrcQ <= 7'h00;
			statusWord <= 12'h000;
			parityErr <= 1'b0;
			eofQ <= 1'b0;
			fmRecQ <= 1'b0;
		end
		else
		begin
			outAccept   <= stateQ == tsf_pkg::ST_WTAKE && outValid;
			fcRejected  <= fcMine && !accept;
			statusValid <= accept && isStat;
			wrStrobe    <= emit || isCheck;
			if (stateQ == tsf_pkg::ST_WTAKE && outValid)
				wordQ <= outData;
			if (isCheck)
				wrFrame <= lrcQ;
			else if (emit)
				wrFrame <= emitFrame;
			if (evWrite || evWfm || isCheck)
				lrcQ <= 7'h00;
			else if (emit)
				lrcQ <= lrcQ ^ emitFrame;
			if (evWrite || evWfm)
				rbLrcQ <= 7'h00;
			else if (rbRise)
				rbLrcQ <= rbLrcQ ^ rbFrS;
			if (accept && isStat)
				statusWord <= statusD;
			if ((rbChk && rbBad) || lrcBad)
				parityErr <= 1'b1;
			else if (evSel && !isStat)
				parityErr <= 1'b0;
			if (evWrite || evWfm)
				fmRecQ <= evWfm;
			if (srchEndV[selHandler])
				eofQ <= 1'b1;
			else if (evSel && !isStat)
				eofQ <= 1'b0;
		end
	end

	// Checks
	record_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
		stateQ == tsf_pkg::ST_WGAP && stateD != tsf_pkg::ST_WGAP |-> dwellQ == TW'(GAP_CYC - 1))
		else $error("record gap wait has wrong length");
	cc_gap_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		stateQ == tsf_pkg::ST_CCGAP && stateD != tsf_pkg::ST_CCGAP
		|-> dwellQ == TW'(3 * FRAME_CYC - 1) ##1 stateQ == tsf_pkg::ST_CHECK)
		else $error("check gap is not three frames");
	high_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrStrobe && wideMode && $past(stateQ) == tsf_pkg::ST_WHI |-> wrFrame[5:0] == wordQ[11:6])
		else $error("high character not sent first");
	low_only_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrStrobe && !wideMode && $past(stateQ) == tsf_pkg::ST_WHI |-> wrFrame[5:0] == wordQ[5:0])
		else $error("six-bit mode sent wrong half");
	frame_parity_a: assert property (@(posedge clk) disable iff (!rst_n)
		wrStrobe && $past(stateQ) inside {tsf_pkg::ST_WHI, tsf_pkg::ST_WLO}
		|-> wrFrame[6] == (parityOdd ? ~^wrFrame[5:0] : ^wrFrame[5:0]))
		else $error("frame parity wrong");
	check_char_a: assert property (@(posedge clk) disable iff (!rst_n)
		isCheck |=> wrStrobe && wrFrame == $past(lrcQ) && lrcQ == 7'h00)
		else $error("check character is not the column parity");
	search_free_a: assert property (@(posedge clk) disable iff (!rst_n)
		evSrchR || evSrchF |=> fsmIdle && busyV[$past(fcX)] && ignoreGap[$past(fcX)])
		else $error("search did not free the sequencer");
	fwd_only_a: assert property (@(posedge clk) disable iff (!rst_n)
		fcMine && isOp && needRev && fwdOnlyV[fcX] |-> !accept ##1 fcRejected)
		else $error("reverse motion accepted after rewind");
	unload_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
		fcMine && isOp && lockV[fcX] |=> fcRejected && !motFwd[$past(fcX)])
		else $error("unloaded handler accepted an operation");
	bsp_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
		stateQ == tsf_pkg::ST_BSP && gapRise[selHandler]
		|=> fsmIdle && !motRev[$past(selHandler)])
		else $error("backspace did not stop at gap");
	unit_filter_a: assert property (@(posedge clk) disable iff (!rst_n)
		fcStrobe && fcUnit != UNIT_DIG |=> $stable(selHandler) && !fcRejected && !statusValid)
		else $error("foreign unit code acted on");
	write_cov: cover property (@(posedge clk) disable iff (!rst_n)
		stateQ == tsf_pkg::ST_REPLY && evStop);
	fm_cov: cover property (@(posedge clk) disable iff (!rst_n)
		stateQ == tsf_pkg::ST_FMWR && emit);
	search_cov: cover property (@(posedge clk) disable iff (!rst_n) |srchEndV);
	rewind_cov: cover property (@(posedge clk) disable iff (!rst_n) |(lpRise & ~lpP & lpS) && |fwdOnlyV);
endmodule

// ==== rtl/tsf_pkg.sv ====
// Constants and types shared by the tape synchronizer function control
package tsf_pkg;
	localparam int     CLK_HZ          = 100_000_000;
	localparam longint CLK_HZ_L        = 64'(CLK_HZ);
	// Tape motion and character timing
	localparam int     TAPE_IPS        = 75;
	localparam int     CHAR_RATE_HZ    = 15_000;
	localparam int     GAP_MILLI_IN    = 750;
	localparam int     FM_GAP_MILLI_IN = 6000;
	localparam int     CC_GAP_FRAMES   = 3;
	localparam int     GAP_CYC         = int'((longint'(GAP_MILLI_IN) * CLK_HZ_L + 1000 * TAPE_IPS - 1)
		/ (1000 * TAPE_IPS));
	localparam int     FM_GAP_CYC      = int'((longint'(FM_GAP_MILLI_IN) * CLK_HZ_L + 1000 * TAPE_IPS - 1)
		/ (1000 * TAPE_IPS));
	localparam int     FRAME_CYC       = (CLK_HZ + CHAR_RATE_HZ - 1) / CHAR_RATE_HZ;
	localparam int     TMR_W           = 24;
	// Function code digits
	localparam logic [2:0] FN_DENS     = 3'h0;
	localparam logic [2:0] FN_WRITE    = 3'h1;
	localparam logic [2:0] FN_BACK     = 3'h2;
	localparam logic [2:0] FN_FWD      = 3'h3;
	localparam logic [2:0] FN_STAT     = 3'h4;
	localparam logic [2:0] FN_UNLOAD   = 3'h5;
	localparam logic [2:0] FN_REWIND   = 3'h6;
	localparam logic [2:0] FN_PARITY   = 3'h7;
	localparam logic [2:0] Y_NARROW    = 3'h1;
	localparam logic [2:0] Y_WIDE      = 3'h2;
	localparam logic [2:0] PAR_ODD_X   = 3'h1;
	localparam logic [2:0] PAR_EVEN_X  = 3'h2;
	localparam logic [5:0] FILE_MARK   = 6'h0F;
	// Status bit positions
	localparam int     ST_EVEN = 0;
	localparam int     ST_NRDY = 1;
	localparam int     ST_PERR = 2;
	localparam int     ST_EOF  = 4;
	localparam int     ST_LDPT = 5;
	localparam int     ST_HIDN = 6;
	localparam int     ST_BUSY = 7;
	// Reset values
	localparam logic   RST_PAR_ODD = 1'b1;
	localparam logic   RST_WIDE    = 1'b0;
	// Density codes and switch pairs
	localparam logic [1:0] DENS_200 = 2'h0;
	localparam logic [1:0] DENS_556 = 2'h1;
	localparam logic [1:0] DENS_800 = 2'h2;
	localparam logic [1:0] PAIR_200_556 = 2'h0;
	localparam logic [1:0] PAIR_200_800 = 2'h1;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_BSP   = 4'h1,
		ST_WGAP  = 4'h3,
		ST_WTAKE = 4'h2,
		ST_WHI   = 4'h6,
		ST_WLO   = 4'h7,
		ST_CCGAP = 4'h5,
		ST_CHECK = 4'h4,
		ST_REPLY = 4'hC,
		ST_FMGAP = 4'hD,
		ST_FMWR  = 4'hF
	} tsf_state_t;
endpackage

// ==== rtl/tsf_sync.sv ====
// Two-flop synchroniser bank for handler sense pins
`timescale 1ns/1ps
module tsf_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Raw and synchronised levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	for (genvar i = 0; i < W; i++)
	begin : g_bit
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				meta_q[i] <= 1'b0;
				dout[i]   <= 1'b0;
			end
			else
			begin
				meta_q[i] <= din[i];
				dout[i]   <= meta_q[i];
			end
		end
	end
endmodule

// ==== rtl/tsf_timer.sv ====
// Loadable down counter for gap and frame timing
`timescale 1ns/1ps
module tsf_timer #(
	parameter int W = 24
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Load and expiry
	input  wire logic         load,
	input  wire logic [W-1:0] loadVal,
	output logic              done
);
	logic [W-1:0] cnt_q;

	// Done marks the last cycle of a loaded interval; it must not look at load,
	// because the sequencer derives load from done and that would close a loop
	assign done = cnt_q == W'(1);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else if (load)
			cnt_q <= loadVal;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - W'(1);
	end
endmodule
